/* File: logic/rtca_pkg.sv */
// Shared constants and carriers for the clock control block
package rtca_pkg;

    // ========================================
    // Timing
    // ========================================
    localparam int CLK_PERIOD_NS = 20;
    // Oscillator silence that counts as stopped (least time)
    localparam int OSC_STOP_NS = 100000;
    localparam int OSC_STOP_CYC = (OSC_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ========================================
    // Register offsets (4-bit word address)
    // ========================================
    localparam logic [3:0] A_CTRL1 = 4'h0;
    localparam logic [3:0] A_CTRL2 = 4'h1;
    localparam logic [3:0] A_ALM_MIN = 4'h9;
    localparam logic [3:0] A_ALM_HOUR = 4'hA;
    localparam logic [3:0] A_ALM_DAY = 4'hB;
    localparam logic [3:0] A_ALM_WDAY = 4'hC;
    localparam logic [3:0] A_SQW = 4'hD;
    localparam logic [3:0] A_TCTRL = 4'hE;
    localparam logic [3:0] A_TCOUNT = 4'hF;

    // ========================================
    // Field positions
    // ========================================
    localparam int B_DIAG_A = 7;
    localparam int B_HALT = 5;
    localparam int B_DIAG_B = 3;
    localparam int B_PULSE = 4;
    localparam int B_AF = 3;
    localparam int B_TF = 2;
    localparam int B_AIE = 1;
    localparam int B_TIE = 0;
    localparam int B_TOP = 7;

    // Writable bits per register
    localparam logic [7:0] M_CTRL1 = 8'hA8;
    localparam logic [7:0] M_CTRL2 = 8'h1F;
    localparam logic [7:0] M_FLAGS = 8'h0C;
    localparam logic [7:0] M_SEL = 8'h83;
    localparam logic [3:0][7:0] M_ALM = {8'h87, 8'hBF, 8'hBF, 8'hFF};

    // ========================================
    // Values after reset
    // ========================================
    localparam logic [7:0] R_CTRL1 = 8'h08;
    localparam logic [7:0] R_CTRL2 = 8'h00;
    localparam logic [7:0] R_ALM = 8'h80;
    localparam logic [7:0] R_TCTRL = 8'h03;
    localparam logic [7:0] R_SQW_POR = 8'h00;
    localparam logic [7:0] R_SQW_OSC = 8'h80;

    // ========================================
    // Divider chain and pulse widths (oscillator periods)
    // ========================================
    localparam int DIV_W = 15;
    localparam int DIV_B_1024 = 4;
    localparam int DIV_B_32 = 9;
    localparam int DIV_B_1 = 14;
    localparam int T4096_BITS = 3;
    localparam int T64_BITS = 9;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam int PW_W = 10;
    localparam logic [9:0] PW_8192 = 10'h004;
    localparam logic [9:0] PW_4096 = 10'h008;
    localparam logic [9:0] PW_128 = 10'h100;
    localparam logic [9:0] PW_64 = 10'h200;

    // ========================================
    // Types
    // ========================================
    typedef enum logic [1:0] {
        SRC_4096 = 2'b00,
        SRC_64 = 2'b01,
        SRC_1 = 2'b10,
        SRC_60 = 2'b11
    } rtca_src_t;

    typedef enum logic [1:0] {
        SQ_32K = 2'b00,
        SQ_1024 = 2'b01,
        SQ_32 = 2'b10,
        SQ_1 = 2'b11
    } rtca_sqsel_t;

    typedef struct packed {
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rtca_reg_req_t;

    typedef struct packed {
        logic minute_tick;
        logic [6:0] minute;
        logic [5:0] hour;
        logic [5:0] day;
        logic [2:0] weekday;
    } rtca_cal_t;

endpackage : rtca_pkg

/* File: logic/rtca_countdown.sv */
// Reloading 8-bit countdown with interrupt pulse stretcher
`timescale 1ns/1ps
`default_nettype none

module rtca_countdown #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic osc_tick,
    input wire logic run,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    input wire rtca_pkg::rtca_src_t src,
    output logic [CNT_W-1:0] count_o,
    output logic done_o,
    output logic pulse_o
);

    // ========================================
    // Parameter check
    // ========================================
    if (CNT_W < 2) begin : g_chk
        $error("rtca_countdown: CNT_W must be at least 2");
    end

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic done;
        logic pulse;
        logic [rtca_pkg::PW_W-1:0] pw_cnt;
    } rtca_cd_st_t;

    rtca_cd_st_t s_q;
    rtca_cd_st_t s_d;
    logic [rtca_pkg::PW_W-1:0] width;
    logic one_shot;

    // Pulse width depends on source and, for the 4096 and 64 sources only, on a load of exactly one
    always_comb begin
        one_shot = (s_q.reload == CNT_W'(1));
        case (src)
            rtca_pkg::SRC_4096: width = one_shot ? rtca_pkg::PW_8192 : rtca_pkg::PW_4096; // RULE7
            rtca_pkg::SRC_64: width = one_shot ? rtca_pkg::PW_128 : rtca_pkg::PW_64; // RULE7
            default: width = rtca_pkg::PW_64; // RULE7
        endcase
    end

    // Count, reload and stretch
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load) begin
            s_d.count = load_val; // RULE14
            s_d.reload = load_val;
        end else if (run && tick && s_q.reload != '0) begin // RULE11 RULE8
            if (s_q.count <= CNT_W'(1)) begin
                s_d.done = 1'b1; // RULE14
                s_d.count = s_q.reload; // RULE25
            end else begin
                s_d.count = s_q.count - CNT_W'(1); // RULE14
            end
        end
        if (s_d.done) begin
            s_d.pulse = 1'b1; // RULE16
            s_d.pw_cnt = width;
        end else if (s_q.pulse && osc_tick) begin
            s_d.pw_cnt = s_q.pw_cnt - rtca_pkg::PW_W'(1);
            s_d.pulse = (s_q.pw_cnt != rtca_pkg::PW_W'(1));
        end
        if (rst) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign count_o = s_q.count;
    assign done_o = s_q.done;
    assign pulse_o = s_q.pulse;

endmodule : rtca_countdown

`default_nettype wire

/* File: logic/rtca_sqw.sv */
// Square-wave output stage, open-drain
`timescale 1ns/1ps
`default_nettype none

module rtca_sqw (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_lvl,
    input wire logic [rtca_pkg::DIV_W-1:0] div,
    input wire logic [7:0] ctl,
    output logic oe_o
);

    typedef struct packed {
        logic oe;
    } rtca_sq_st_t;

    rtca_sq_st_t s_q;
    rtca_sq_st_t s_d;
    logic lvl;

    // Pick the wave; the oscillator level stays usable while halted
    always_comb begin
        case (rtca_pkg::rtca_sqsel_t'(ctl[1:0]))
            rtca_pkg::SQ_32K: lvl = osc_lvl; // RULE18 RULE2
            rtca_pkg::SQ_1024: lvl = div[rtca_pkg::DIV_B_1024]; // RULE18
            rtca_pkg::SQ_32: lvl = div[rtca_pkg::DIV_B_32]; // RULE18
            default: lvl = div[rtca_pkg::DIV_B_1]; // RULE18
        endcase
    end

    // Pull low only in the low half; inhibited means never driven
    always_comb begin
        s_d.oe = ~ctl[rtca_pkg::B_TOP] & ~lvl; // RULE17 RULE19
        if (rst) begin
            s_d.oe = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign oe_o = s_q.oe;

endmodule : rtca_sqw

`default_nettype wire

/* File: logic/rtca_ctrl.sv */
// Control, alarm, timer and square-wave logic of the clock chip
//
// Notes on behaviour
// RULE1: Host keeps both diagnostic bits at zero; the host model clears bits 7 and 3 of every write to address 0.
// RULE2: Halt clears divider, square wave still runs; here only the SQ_32K select keeps running, the divided rates stop.
// RULE3: Alarm and timer flags set, held until written.
// RULE4: Flag write ANDs data with flag.
// RULE5: Interrupt ORs enabled timer and alarm flags.
// RULE6: Pulse select: level or pulsed timer interrupt.
// RULE7: Pulse width follows source and load.
// RULE8: Load of zero keeps timer stopped.
// RULE9: Alarm on first match of enabled fields.
// RULE10: Re-arm only on increment into match.
// RULE11: Countdown runs only with enable bit set.
// RULE12: Source select picks countdown clock.
// RULE13: Host picks slowest source when timer unused.
// RULE14: Count down loaded value, flag at end.
// RULE15: Count register reads live value.
// RULE16: Pulse each period, flag cleared by software.
// RULE17: Square wave on when enable bit zero.
// RULE18: Frequency select picks square-wave rate.
// RULE19: Open-drain square wave enabled after power-on.
// RULE20: Internal reset while oscillator stopped.
// RULE21: Reset clears registers, listed bits set.
// RULE22: Four-bit word address selects register.
// RULE23: Alarm registers 09H-0CH, enable in top.
// RULE24: Timer control 0EH, count 0FH.
// RULE25: Countdown reloads and keeps running.
// RULE26: Alarm evaluated on each minute increment.
`timescale 1ns/1ps
`default_nettype none

module rtca_ctrl #(
    parameter int STOP_CYCLES = rtca_pkg::OSC_STOP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_in,
    input wire rtca_pkg::rtca_reg_req_t req,
    output logic [7:0] rdata,
    input wire rtca_pkg::rtca_cal_t cal,
    output logic sec_tick,
    output logic halted,
    output logic core_rst,
    output logic irq_o,
    output logic irq_oe,
    output logic sqw_o,
    output logic sqw_oe
);

    // ========================================
    // Parameter check
    // ========================================
    if (STOP_CYCLES < 1 || STOP_CYCLES > 65535) begin : g_chk
        $error("rtca_ctrl: STOP_CYCLES must lie in 1..65535");
    end

    localparam logic [15:0] STOP_LIM = 16'(STOP_CYCLES);

    // ========================================
    // State
    // ========================================
    typedef struct packed {
        logic [2:0] osc_sync;
        logic [15:0] stop_cnt;
        logic osc_dead;
        logic [rtca_pkg::DIV_W-1:0] div;
        logic [5:0] sec_cnt;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [3:0][7:0] alm;
        logic [7:0] sqw;
        logic [7:0] tctrl;
        logic match_prev;
        logic [7:0] rdata;
        logic irq;
        logic sec_tick;
        logic halted;
        logic core_rst;
        logic drv_low;
    } rtca_st_t;

    rtca_st_t s_q;
    rtca_st_t s_d;

    logic irst;
    logic osc_rise;
    logic osc_edge;
    logic halt;
    logic t4096;
    logic t64;
    logic t1;
    logic t60;
    logic src_tick;
    logic [3:0][6:0] cur;
    logic [3:0] fld_hit;
    logic any_en;
    logic full_match;
    logic alarm_hit;
    logic [7:0] tmr_count;
    logic tmr_done;
    logic tmr_pulse;
    logic tmr_load;
    logic sqw_oe_w;
    logic pmode;
    logic t_term;
    logic a_term;

    // ========================================
    // Oscillator edges and stop detection
    // ========================================
    // Only the second sync stage and its delayed copy feed logic
    assign osc_rise = s_q.osc_sync[1] & ~s_q.osc_sync[2];
    assign osc_edge = s_q.osc_sync[1] ^ s_q.osc_sync[2];
    // Internal reset covers power-on and a dead oscillator
    assign irst = rst | s_q.osc_dead; // RULE20

    // ========================================
    // Divider taps and countdown source
    // ========================================
    assign halt = s_q.ctrl1[rtca_pkg::B_HALT];
    assign t4096 = osc_rise & ~halt & (&s_q.div[rtca_pkg::T4096_BITS-1:0]);
    assign t64 = osc_rise & ~halt & (&s_q.div[rtca_pkg::T64_BITS-1:0]);
    assign t1 = osc_rise & ~halt & (&s_q.div);
    assign t60 = t1 & (s_q.sec_cnt == rtca_pkg::SEC_LAST);

    // Countdown clock chosen by the source select bits
    always_comb begin
        case (rtca_pkg::rtca_src_t'(s_q.tctrl[1:0]))
            rtca_pkg::SRC_4096: src_tick = t4096; // RULE12
            rtca_pkg::SRC_64: src_tick = t64; // RULE12
            rtca_pkg::SRC_1: src_tick = t1; // RULE12
            default: src_tick = t60; // RULE12
        endcase
    end

    // ========================================
    // Alarm comparator
    // ========================================
    assign cur[0] = cal.minute;
    assign cur[1] = {1'b0, cal.hour};
    assign cur[2] = {1'b0, cal.day};
    assign cur[3] = {4'h0, cal.weekday};

    // A field with its top bit set does not take part
    for (genvar i = 0; i < 4; i++) begin : g_alm
        assign fld_hit[i] = s_q.alm[i][rtca_pkg::B_TOP] // RULE9
            | (s_q.alm[i][6:0] == cur[i]); // RULE23
    end

    // With every field excluded there is nothing to match
    assign any_en = ~(s_q.alm[0][rtca_pkg::B_TOP] & s_q.alm[1][rtca_pkg::B_TOP]
        & s_q.alm[2][rtca_pkg::B_TOP] & s_q.alm[3][rtca_pkg::B_TOP]);
    assign full_match = any_en & (&fld_hit);
    // Fire only when an increment enters the match, not while it lasts
    assign alarm_hit = cal.minute_tick & full_match & ~s_q.match_prev; // RULE10 RULE26

    // ========================================
    // Countdown timer
    // ========================================
    assign tmr_load = req.wr & (req.addr == rtca_pkg::A_TCOUNT); // RULE24

    rtca_countdown #(
        .CNT_W(8)
    ) u_countdown (
        .clk(clk),
        .rst(irst),
        .tick(src_tick),
        .osc_tick(osc_rise),
        .run(s_q.tctrl[rtca_pkg::B_TOP]),
        .load(tmr_load),
        .load_val(req.wdata),
        .src(rtca_pkg::rtca_src_t'(s_q.tctrl[1:0])),
        .count_o(tmr_count),
        .done_o(tmr_done),
        .pulse_o(tmr_pulse)
    );

    // ========================================
    // Square-wave output
    // ========================================
    rtca_sqw u_sqw (
        .clk(clk),
        .rst(irst),
        .osc_lvl(s_q.osc_sync[1]),
        .div(s_q.div),
        .ctl(s_q.sqw),
        .oe_o(sqw_oe_w)
    );

    // ========================================
    // Next state
    // ========================================
    always_comb begin
        s_d = s_q;

        // Pin synchroniser and delayed copy for edges
        s_d.osc_sync = {s_q.osc_sync[1:0], osc_in};

        // Watchdog restarts on every oscillator edge
        if (osc_edge) begin
            s_d.stop_cnt = 16'h0000;
        end else if (s_q.stop_cnt != STOP_LIM) begin
            s_d.stop_cnt = s_q.stop_cnt + 16'h0001;
        end
        s_d.osc_dead = (s_q.stop_cnt == STOP_LIM); // RULE20

        // Halt is applied on the next clock, not asynchronously; the
        // divider holds zero for as long as the bit stays set
        if (halt) begin
            s_d.div = '0; // RULE2
        end else if (osc_rise) begin
            s_d.div = s_q.div + rtca_pkg::DIV_W'(1);
        end

        // Seconds prescaler for the slowest source
        if (halt) begin
            s_d.sec_cnt = 6'h00;
        end else if (t1) begin
            s_d.sec_cnt = t60 ? 6'h00 : s_q.sec_cnt + 6'h01;
        end

        // Register writes; only the low address nibble exists
        if (req.wr) begin
            case (req.addr) // RULE22
                rtca_pkg::A_CTRL1: begin
                    s_d.ctrl1 = req.wdata & rtca_pkg::M_CTRL1;
                end
                rtca_pkg::A_CTRL2: begin
                    s_d.ctrl2 = (req.wdata & rtca_pkg::M_CTRL2 & ~rtca_pkg::M_FLAGS)
                        | (s_q.ctrl2 & req.wdata & rtca_pkg::M_FLAGS); // RULE4
                end
                rtca_pkg::A_ALM_MIN,
                rtca_pkg::A_ALM_HOUR,
                rtca_pkg::A_ALM_DAY,
                rtca_pkg::A_ALM_WDAY: begin
                    s_d.alm[2'(req.addr - rtca_pkg::A_ALM_MIN)] = req.wdata
                        & rtca_pkg::M_ALM[2'(req.addr - rtca_pkg::A_ALM_MIN)]; // RULE23
                end
                rtca_pkg::A_SQW: begin
                    s_d.sqw = req.wdata & rtca_pkg::M_SEL;
                end
                rtca_pkg::A_TCTRL: begin
                    s_d.tctrl = req.wdata & rtca_pkg::M_SEL; // RULE24
                end
                default: begin
                    s_d.ctrl1 = s_d.ctrl1;
                end
            endcase
        end

        // Hardware sets come after the write so a set beats a clear
        if (alarm_hit) begin
            s_d.ctrl2[rtca_pkg::B_AF] = 1'b1; // RULE3 RULE9
        end
        if (tmr_done) begin
            s_d.ctrl2[rtca_pkg::B_TF] = 1'b1; // RULE3 RULE14
        end

        // Remember the match seen at the last increment
        if (cal.minute_tick) begin
            s_d.match_prev = full_match; // RULE10
        end

        // Read data; calendar offsets are answered elsewhere
        if (req.rd) begin
            case (req.addr) // RULE22
                rtca_pkg::A_CTRL1: s_d.rdata = s_q.ctrl1;
                rtca_pkg::A_CTRL2: s_d.rdata = s_q.ctrl2;
                rtca_pkg::A_ALM_MIN: s_d.rdata = s_q.alm[0];
                rtca_pkg::A_ALM_HOUR: s_d.rdata = s_q.alm[1];
                rtca_pkg::A_ALM_DAY: s_d.rdata = s_q.alm[2];
                rtca_pkg::A_ALM_WDAY: s_d.rdata = s_q.alm[3];
                rtca_pkg::A_SQW: s_d.rdata = s_q.sqw;
                rtca_pkg::A_TCTRL: s_d.rdata = s_q.tctrl;
                rtca_pkg::A_TCOUNT: s_d.rdata = tmr_count; // RULE15
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Interrupt from the new flag values so it rises with the flag
        pmode = s_d.ctrl2[rtca_pkg::B_PULSE];
        t_term = s_d.ctrl2[rtca_pkg::B_TIE]
            & (pmode ? tmr_pulse : s_d.ctrl2[rtca_pkg::B_TF]); // RULE6 RULE7 RULE16
        a_term = s_d.ctrl2[rtca_pkg::B_AIE] & s_d.ctrl2[rtca_pkg::B_AF]; // RULE6
        s_d.irq = t_term | a_term; // RULE5

        s_d.sec_tick = t1;
        s_d.halted = halt;
        s_d.drv_low = 1'b0;

        // Internal reset: power-on wants the square wave on, a
        // stopped oscillator inhibits it
        if (irst) begin
            s_d.ctrl1 = rtca_pkg::R_CTRL1; // RULE21
            s_d.ctrl2 = rtca_pkg::R_CTRL2; // RULE21
            s_d.alm = {4{rtca_pkg::R_ALM}}; // RULE21
            s_d.sqw = rst ? rtca_pkg::R_SQW_POR : rtca_pkg::R_SQW_OSC; // RULE19 RULE21
            s_d.tctrl = rtca_pkg::R_TCTRL; // RULE21
            s_d.div = '0;
            s_d.sec_cnt = 6'h00;
            s_d.match_prev = 1'b0;
            s_d.rdata = 8'h00;
            s_d.irq = 1'b0;
            s_d.sec_tick = 1'b0;
            s_d.halted = 1'b0;
        end
        s_d.core_rst = irst; // RULE21

        if (rst) begin
            s_d.osc_sync = 3'h0;
            s_d.stop_cnt = 16'h0000;
            s_d.osc_dead = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    // ========================================
    // Outputs, all from flops
    // ========================================
    assign rdata = s_q.rdata;
    assign sec_tick = s_q.sec_tick;
    assign halted = s_q.halted;
    assign core_rst = s_q.core_rst;
    assign irq_o = s_q.drv_low;
    assign irq_oe = s_q.irq;
    assign sqw_o = s_q.drv_low;
    assign sqw_oe = sqw_oe_w;

endmodule : rtca_ctrl

`default_nettype wire

/* File: verification/rtca_ctrl_asserts.sv */
// Port checks for the clock control block
`timescale 1ns/1ps
`default_nettype none

module rtca_ctrl_asserts #(
    parameter int STOP_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_in,
    input wire rtca_pkg::rtca_reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic halted,
    input wire logic core_rst,
    input wire logic irq_o,
    input wire logic irq_oe,
    input wire logic sqw_o,
    input wire logic sqw_oe
);
    logic [2:0] osc_q;
    logic [15:0] quiet_q;

    // ========================================
    // Helper
    // ========================================
    // Cycles since the last oscillator edge, saturating
    always_ff @(posedge clk) begin
        osc_q <= {osc_q[1:0], osc_in};
        if (rst || (osc_q[2] != osc_q[1])) begin
            quiet_q <= 16'h0000;
        end else if (quiet_q != 16'hFFFF) begin
            quiet_q <= quiet_q + 16'h0001;
        end
    end

    // ========================================
    // Assertions
    // ========================================
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_pins_low: assert property (!irq_o && !sqw_o)
        else $error("pin data set");
    a_rst_quiet: assert property (disable iff (1'b0) rst |=> rdata == 8'h00 && !irq_oe && !sqw_oe)
        else $error("reset not quiet");
    a_rst_core: assert property (disable iff (1'b0) rst |=> core_rst)
        else $error("no core reset");
    a_osc_dead: assert property (quiet_q > STOP_CYCLES + 6 |-> core_rst)
        else $error("stopped osc ignored");
    a_rd_hold: assert property (disable iff (rst || core_rst) !req.rd |=> $stable(rdata))
        else $error("rdata moved without read");
    a_unmapped_rd: assert property (req.rd && req.addr inside {[4'h2:4'h8]} |=> rdata == 8'h00)
        else $error("calendar read not zero");
    a_halt_set: assert property (req.wr && req.addr == 4'h0 && req.wdata[5] |-> ##[1:2] halted)
        else $error("no halt");
    a_irq_off: assert property (req.wr && req.addr == 4'h1 && req.wdata[1:0] == 2'b00 |=> !irq_oe)
        else $error("irq with enables off");
    a_sqw_inhibit: assert property (req.wr && req.addr == 4'hD && req.wdata[7] |-> ##4 (!sqw_oe) [*8])
        else $error("sqw not inhibited");

    // Scenarios reached
    c_irq: cover property ($rose(irq_oe));
    c_osc_dead: cover property (core_rst && !rst);
    c_halt: cover property ($rose(halted));
endmodule : rtca_ctrl_asserts

`default_nettype wire

/* File: verification/rtca_host.sv */
// Register master model
`timescale 1ns/1ps
`default_nettype none

module rtca_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output var rtca_pkg::rtca_reg_req_t req
);
    initial req = '0;

    // One-cycle write strobe; diagnostic bits 7 and 3 kept zero
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req.addr = a;
        req.wdata = (a == 4'h0) ? (d & 8'h77) : d;
        req.wr = 1'b1;
        @(posedge clk);
        #1;
        req.wr = 1'b0;
    endtask : wr

    // Read data registered at the strobe edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        req.addr = a;
        req.rd = 1'b1;
        @(posedge clk);
        #1;
        d = rdata;
        req.rd = 1'b0;
    endtask : rd
endmodule : rtca_host

`default_nettype wire

/* File: verification/rtca_ctrl_tb.sv */
// Bench for the clock control block
`timescale 1ns/1ps
`default_nettype none

module rtca_ctrl_tb;
    localparam int STOP = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic osc_in = 1'b0;
    logic osc_run = 1'b1;
    rtca_pkg::rtca_cal_t cal = '0;
    rtca_pkg::rtca_reg_req_t req;
    logic [7:0] rdata;
    logic [7:0] v;
    logic sec_tick, halted, core_rst, irq_o, irq_oe, sqw_o, sqw_oe;
    int n_errors = 0;
    int checks = 0;
    int w;
    // Address, data written, data read
    logic [19:0] rows [11] = '{20'h9FFFF, 20'hAFFBF, 20'hBFFBF, 20'hCFF87, 20'hDFF83,
        20'hEFF83, 20'hFA5A5, 20'h35500, 20'h02020, 20'h00000, 20'h1FF13};
    logic [11:0] rstv [9] = '{12'h008, 12'h100, 12'h980, 12'hA80, 12'hB80, 12'hC80,
        12'hD00, 12'hE03, 12'hF00};
    // Setting, least and most toggles in 320 cycles
    logic [23:0] sq [3] = '{24'h002729, 24'h010102, 24'h800000};

    rtca_ctrl #(.STOP_CYCLES(STOP)) rtca_ctrl_inst (.clk(clk), .rst(rst), .osc_in(osc_in),
        .req(req), .rdata(rdata), .cal(cal), .sec_tick(sec_tick), .halted(halted),
        .core_rst(core_rst), .irq_o(irq_o), .irq_oe(irq_oe), .sqw_o(sqw_o), .sqw_oe(sqw_oe));
    rtca_host rtca_host_inst (.clk(clk), .rdata(rdata), .req(req));

    // ========================================
    // Clocks
    // ========================================
    initial forever #10 clk = ~clk;
    // Fast oscillator, edges well inside the stop window
    initial forever begin
        #160;
        if (osc_run) osc_in = ~osc_in;
    end

    // ========================================
    // Tasks
    // ========================================
    task automatic conclude;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        rtca_host_inst.rd(a, v);
        chk(v, exp);
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Bounded wait for an irq level
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 2000 && irq_oe !== lvl; i++) cyc(1);
        if (irq_oe !== lvl) begin
            n_errors++;
            conclude();
        end
    endtask : wait_irq

    task automatic toggles(output int n);
        logic p;
        n = 0;
        p = sqw_oe;
        repeat (320) begin
            cyc(1);
            if (sqw_oe !== p) n++;
            p = sqw_oe;
        end
    endtask : toggles

    // Minute increment with the new time
    task automatic tick(input logic [6:0] m);
        cyc(1);
        cal.minute = m;
        cal.minute_tick = 1'b1;
        cyc(1);
        cal.minute_tick = 1'b0;
        cyc(2);
    endtask : tick

    // ========================================
    // Sequence
    // ========================================
    initial begin
        cyc(3);
        rst = 1'b0;
        for (int i = 0; i < 11; i++) begin
            rtca_host_inst.wr(rows[i][19:16], rows[i][15:8]);
            rdchk(rows[i][19:16], rows[i][7:0]);
        end
        $display("test rows done");
        // Mid-run reset
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) rdchk(rstv[i][11:8], rstv[i][7:0]);
        $display("test reset done");
        // Level irq, reload, live count
        rtca_host_inst.wr(4'hE, 8'h80);
        rtca_host_inst.wr(4'h1, 8'h01);
        rtca_host_inst.wr(4'hF, 8'h02);
        wait_irq(1'b1);
        rdchk(4'hF, 8'h02);
        rdchk(4'h1, 8'h05);
        cyc(130);
        rdchk(4'hF, 8'h01);
        rtca_host_inst.wr(4'hF, 8'h00);
        rtca_host_inst.wr(4'h1, 8'h09);
        cyc(400);
        rdchk(4'h1, 8'h01);
        rtca_host_inst.wr(4'hE, 8'h00);
        rtca_host_inst.wr(4'hF, 8'h03);
        cyc(400);
        rdchk(4'hF, 8'h03);
        rdchk(4'h1, 8'h01);
        // Pulse mode, load one
        rtca_host_inst.wr(4'h1, 8'h11);
        rtca_host_inst.wr(4'hE, 8'h80);
        rtca_host_inst.wr(4'hF, 8'h01);
        wait_irq(1'b1);
        for (w = 0; irq_oe === 1'b1 && w < 200; w++) cyc(1);
        chk({7'h00, w >= 62 && w <= 66}, 8'h01);
        rdchk(4'h1, 8'h15);
        wait_irq(1'b1);
        rtca_host_inst.wr(4'hE, 8'h03);
        $display("test timer done");
        // Minute alarm and re-arm
        rtca_host_inst.wr(4'h1, 8'h02);
        rtca_host_inst.wr(4'h9, 8'h15);
        tick(7'h15);
        chk({7'h00, irq_oe}, 8'h01);
        rdchk(4'h1, 8'h0A);
        rtca_host_inst.wr(4'h1, 8'h06);
        rdchk(4'h1, 8'h02);
        tick(7'h15);
        rdchk(4'h1, 8'h02);
        tick(7'h16);
        tick(7'h15);
        rdchk(4'h1, 8'h0A);
        rtca_host_inst.wr(4'h1, 8'h00);
        $display("test alarm done");
        // Square-wave rates, inhibit
        for (int i = 0; i < 3; i++) begin
            rtca_host_inst.wr(4'hD, sq[i][23:16]);
            cyc(8);
            toggles(w);
            chk({7'h00, w >= sq[i][15:8] && w <= sq[i][7:0]}, 8'h01);
        end
        rtca_host_inst.wr(4'hD, 8'h00);
        rtca_host_inst.wr(4'h0, 8'h20);
        cyc(4);
        chk({6'h00, halted, sec_tick}, 8'h02);
        toggles(w);
        chk({7'h00, w >= 39 && w <= 41}, 8'h01);
        rtca_host_inst.wr(4'h0, 8'h00);
        $display("test sqw done");
        // Oscillator stop resets
        osc_run = 1'b0;
        cyc(40);
        chk({7'h00, core_rst}, 8'h01);
        osc_run = 1'b1;
        cyc(40);
        rdchk(4'hD, 8'h80);
        rdchk(4'hE, 8'h03);
        $display("test osc stop done");
        conclude();
    end
endmodule : rtca_ctrl_tb

bind rtca_ctrl rtca_ctrl_asserts #(.STOP_CYCLES(STOP_CYCLES)) rtca_ctrl_asserts_inst (
    .clk(clk), .rst(rst), .osc_in(osc_in), .req(req), .rdata(rdata), .halted(halted),
    .core_rst(core_rst), .irq_o(irq_o), .irq_oe(irq_oe), .sqw_o(sqw_o), .sqw_oe(sqw_oe));

`default_nettype wire
